// *** hw/i2c_st_defines.svh ***
// Register offsets, field positions, status codes and reset values of the two-wire slave transmitter.
// Assumes byte addressing on Avalon-MM with one 32-bit word per register.
`ifndef I2C_ST_DEFINES_SVH
`define I2C_ST_DEFINES_SVH

`define REG_CONTROL     3'h0
`define REG_STATUS      3'h1
`define REG_DATA        3'h2
`define REG_OWN_ADDR    3'h3
`define REG_IRQ_STATUS  3'h4
`define REG_IRQ_MASK    3'h5

`define CTRL_FLAG_BIT   7
`define CTRL_ACK_BIT    6
`define CTRL_START_BIT  5
`define CTRL_STOP_BIT   4
`define CTRL_EN_BIT     2

`define IRQ_DONE_BIT    0
`define IRQ_ERROR_BIT   1
`define IRQ_START_BIT   2

`define CODE_OWN_READ   8'hA8
`define CODE_ARB_READ   8'hB0
`define CODE_DATA_ACK   8'hB8
`define CODE_DATA_NACK  8'hC0
`define CODE_LAST_ACK   8'hC8
`define CODE_NO_INFO    8'hF8
`define CODE_BUS_ERROR  8'h00

`define OWN_ADDR_RESET  8'h00
`define PRESCALE_RESET  2'h0
`define BITS_PER_BYTE   4'h8

`endif

// *** hw/i2c_st_pkg.sv ***
// Types shared by the two-wire slave transmitter.
// Assumes the constants header is included by the design file that uses these types.
package i2c_st_pkg;

    typedef struct packed {
        logic job_done_flag;
        logic ack_enable;
        logic start_request;
        logic stop_request;
        logic enable;
    } ctrl_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WAIT,
        ST_TX,
        ST_TX_ACK,
        ST_ERROR
    } state_e;

endpackage : i2c_st_pkg

// *** hw/i2c_slave_tx_status.sv ***
// Two-wire slave transmitter with status codes, bus-error recovery and START request.
// Assumes an Avalon-MM master on clock and an open-drain bus resolved outside from the enables.
`timescale 1ns/1ps
`include "i2c_st_defines.svh"

module i2c_slave_tx_status (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);

    i2c_st_pkg::ctrl_s  ctrl;
    i2c_st_pkg::state_e state;
    logic [7:0] data_reg;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    logic [7:0] own_addr;
    logic [1:0] prescaler;
    logic [7:0] code;
    logic [3:0] bit_cnt;
    logic       last_byte;
    logic       master_acked;
    logic       raise;
    logic       error_event;
    logic       bus_busy;
    logic       start_drive;
    logic       arb_lost;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic       ack_q;
    logic       scl_meta;
    logic       scl_s;
    logic       scl_q;
    logic       sda_meta;
    logic       sda_s;
    logic       sda_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic       wr_go;
    logic       rd_go;
    logic       ctrl_wr;
    logic       resume;
    logic       recover;
    logic [7:0] status_view;

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    // Two flip-flops on each line, then a third stage for edge finding.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            scl_meta <= 1'b1;
            scl_s    <= 1'b1;
            scl_q    <= 1'b1;
            sda_meta <= 1'b1;
            sda_s    <= 1'b1;
            sda_q    <= 1'b1;
        end
        else
        begin
            scl_meta <= scl_in;
            scl_s    <= scl_meta;
            scl_q    <= scl_s;
            sda_meta <= sda_in;
            sda_s    <= sda_meta;
            sda_q    <= sda_s;
        end
    end

    assign scl_rise   = scl_s & ~scl_q;
    assign scl_fall   = ~scl_s & scl_q;
    assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_seen  = scl_s & scl_q & ~sda_q & sda_s;

    // Every access waits one cycle; the answer edge is the one where waitrequest is low.
    assign waitrequest = (read | write) & ~ack_q;
    assign wr_go       = write & ack_q;
    assign rd_go       = read & ack_q;
    assign ctrl_wr     = wr_go && address[4:2] == `REG_CONTROL;
    assign resume      = ctrl_wr & writedata[`CTRL_FLAG_BIT] & ctrl.job_done_flag;
    assign recover     = resume & writedata[`CTRL_STOP_BIT];
    assign status_view = ctrl.job_done_flag ? code : `CODE_NO_INFO;
    assign irq         = |(irq_status & irq_mask);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ack_q <= 1'b0;
        else
            ack_q <= (read | write) & ~ack_q;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            readdata <= 32'h0000_0000;
        else if ((read | write) & ~ack_q)
        begin
            unique case (address[4:2])
                `REG_CONTROL:    readdata <= {24'h00_0000, ctrl.job_done_flag, ctrl.ack_enable,
                                              ctrl.start_request, ctrl.stop_request, 1'b0,
                                              ctrl.enable, 2'b00};
                `REG_STATUS:     readdata <= {24'h00_0000, status_view[7:3], 1'b0, prescaler};
                `REG_DATA:       readdata <= {24'h00_0000, data_reg};
                `REG_OWN_ADDR:   readdata <= {24'h00_0000, own_addr};
                `REG_IRQ_STATUS: readdata <= {29'h0000_0000, irq_status};
                `REG_IRQ_MASK:   readdata <= {29'h0000_0000, irq_mask};
                default:         readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control bits; a hardware set of the flag wins over a software clear in the same cycle.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ctrl <= '0;
        else
        begin
            if (ctrl_wr)
            begin
                ctrl.ack_enable    <= writedata[`CTRL_ACK_BIT];
                ctrl.start_request <= writedata[`CTRL_START_BIT];
                ctrl.stop_request  <= writedata[`CTRL_STOP_BIT] & ~recover;
                ctrl.enable        <= writedata[`CTRL_EN_BIT];
            end
            if (raise)
                ctrl.job_done_flag <= 1'b1;
            else if (resume)
                ctrl.job_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            data_reg  <= 8'h00;
            own_addr  <= `OWN_ADDR_RESET;
            prescaler <= `PRESCALE_RESET;
            irq_mask  <= 3'h0;
        end
        else if (wr_go)
        begin
            if (address[4:2] == `REG_DATA && ctrl.job_done_flag)
                data_reg <= writedata[7:0];
            if (address[4:2] == `REG_OWN_ADDR)
                own_addr <= writedata[7:0];
            if (address[4:2] == `REG_STATUS)
                prescaler <= writedata[1:0];
            if (address[4:2] == `REG_IRQ_MASK)
                irq_mask <= writedata[2:0];
        end
    end

    // Sticky events, cleared by a read of the interrupt status word unless a new event arrives.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            irq_status <= 3'h0;
        else
        begin
            // Cleared at the edge where the read word is captured, so an event after that edge survives.
            for (int i = 0; i < 3; i++)
            begin
                if (read && !ack_q && address[4:2] == `REG_IRQ_STATUS)
                    irq_status[i] <= 1'b0;
            end
            if (raise)
                irq_status[`IRQ_DONE_BIT] <= 1'b1;
            if (error_event)
                irq_status[`IRQ_ERROR_BIT] <= 1'b1;
            if (start_drive && !sda_oe)
                irq_status[`IRQ_START_BIT] <= 1'b1;
        end
    end

    // Bus free tracking and START generation while not addressed.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            bus_busy    <= 1'b0;
            start_drive <= 1'b0;
            arb_lost    <= 1'b0;
        end
        else
        begin
            if (start_seen)
                bus_busy <= 1'b1;
            else if (stop_seen)
                bus_busy <= 1'b0;
            if (!ctrl.start_request || !ctrl.enable)
                start_drive <= 1'b0;
            else if (state == i2c_st_pkg::ST_IDLE && !bus_busy && !ctrl.job_done_flag && scl_s && sda_s)
                start_drive <= 1'b1;
            if (start_seen && ctrl.start_request && !start_drive)
                arb_lost <= 1'b1;
            else if (raise || !ctrl.start_request)
                arb_lost <= 1'b0;
        end
    end

    // Protocol engine: address match, byte shifting, acknowledge and status codes.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state        <= i2c_st_pkg::ST_IDLE;
            code         <= `CODE_NO_INFO;
            bit_cnt      <= 4'h0;
            rx_shift     <= 8'h00;
            tx_shift     <= 8'h00;
            last_byte    <= 1'b0;
            master_acked <= 1'b0;
            raise        <= 1'b0;
            error_event  <= 1'b0;
            sda_oe       <= 1'b0;
            scl_oe       <= 1'b0;
        end
        else
        begin
            raise       <= 1'b0;
            error_event <= 1'b0;
            if (!ctrl.enable)
            begin
                state  <= i2c_st_pkg::ST_IDLE;
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
            end
            else if ((start_seen || stop_seen) && (state == i2c_st_pkg::ST_ADDR_ACK ||
                     state == i2c_st_pkg::ST_TX || state == i2c_st_pkg::ST_TX_ACK ||
                     (state == i2c_st_pkg::ST_ADDR && bit_cnt != 4'h0)))
            begin
                state       <= i2c_st_pkg::ST_ERROR;
                code        <= `CODE_BUS_ERROR;
                raise       <= 1'b1;
                error_event <= 1'b1;
                sda_oe      <= 1'b0;
                scl_oe      <= 1'b0;
            end
            else
            begin
                unique case (state)
                    i2c_st_pkg::ST_IDLE:
                    begin
                        sda_oe  <= start_drive;
                        bit_cnt <= 4'h0;
                        if (start_seen && !start_drive)
                            state <= i2c_st_pkg::ST_ADDR;
                    end
                    i2c_st_pkg::ST_ADDR:
                    begin
                        if (stop_seen)
                            state <= i2c_st_pkg::ST_IDLE;
                        else if (scl_rise)
                        begin
                            rx_shift <= {rx_shift[6:0], sda_s};
                            bit_cnt  <= bit_cnt + 4'h1;
                        end
                        else if (scl_fall && bit_cnt == `BITS_PER_BYTE)
                        begin
                            // Only an own read address is taken; ack_enable low hides the device.
                            if (rx_shift[7:1] == own_addr[7:1] && rx_shift[0] && ctrl.ack_enable)
                            begin
                                state  <= i2c_st_pkg::ST_ADDR_ACK;
                                sda_oe <= 1'b1;
                            end
                            else
                                state <= i2c_st_pkg::ST_IDLE;
                        end
                    end
                    i2c_st_pkg::ST_ADDR_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe <= 1'b0;
                            scl_oe <= 1'b1;
                            code   <= arb_lost ? `CODE_ARB_READ : `CODE_OWN_READ;
                            raise  <= 1'b1;
                            state  <= i2c_st_pkg::ST_WAIT;
                        end
                    end
                    i2c_st_pkg::ST_WAIT:
                    begin
                        if (resume)
                        begin
                            scl_oe <= 1'b0;
                            if (recover || code == `CODE_DATA_NACK || code == `CODE_LAST_ACK)
                                state <= i2c_st_pkg::ST_IDLE;
                            else
                            begin
                                tx_shift  <= {data_reg[6:0], 1'b0};
                                sda_oe    <= ~data_reg[7];
                                last_byte <= ~writedata[`CTRL_ACK_BIT];
                                bit_cnt   <= 4'h1;
                                state     <= i2c_st_pkg::ST_TX;
                            end
                        end
                    end
                    i2c_st_pkg::ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt == `BITS_PER_BYTE)
                            begin
                                sda_oe <= 1'b0;
                                state  <= i2c_st_pkg::ST_TX_ACK;
                            end
                            else
                            begin
                                sda_oe   <= ~tx_shift[7];
                                tx_shift <= {tx_shift[6:0], 1'b0};
                                bit_cnt  <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    i2c_st_pkg::ST_TX_ACK:
                    begin
                        if (scl_rise)
                            master_acked <= ~sda_s;
                        else if (scl_fall)
                        begin
                            if (!master_acked)
                                code <= `CODE_DATA_NACK;
                            else if (last_byte)
                                code <= `CODE_LAST_ACK;
                            else
                                code <= `CODE_DATA_ACK;
                            raise  <= 1'b1;
                            scl_oe <= 1'b1;
                            state  <= i2c_st_pkg::ST_WAIT;
                        end
                    end
                    i2c_st_pkg::ST_ERROR:
                    begin
                        sda_oe <= 1'b0;
                        scl_oe <= 1'b0;
                        if (recover)
                            state <= i2c_st_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    no_info_a: assert property (@(posedge clock) disable iff (!rst_n)
        rd_go && address[4:2] == `REG_STATUS && !$past(ctrl.job_done_flag)
        |-> {readdata[7:3], 3'h0} == `CODE_NO_INFO)
        else $error("status not 0xF8 while flag clear");

    own_read_a: assert property (@(posedge clock) disable iff (!rst_n)
        state == i2c_st_pkg::ST_ADDR_ACK && scl_fall && !arb_lost && !start_seen && !stop_seen && ctrl.enable
        |=> ##1 ctrl.job_done_flag && status_view == `CODE_OWN_READ)
        else $error("own read not reported as 0xA8");

    data_code_a: assert property (@(posedge clock) disable iff (!rst_n)
        state == i2c_st_pkg::ST_TX_ACK && scl_fall && master_acked && !last_byte && ctrl.enable
        && !start_seen && !stop_seen |=> code == `CODE_DATA_ACK && state == i2c_st_pkg::ST_WAIT)
        else $error("acked byte not reported as 0xB8");

    nack_code_a: assert property (@(posedge clock) disable iff (!rst_n)
        state == i2c_st_pkg::ST_TX_ACK && scl_fall && !master_acked && ctrl.enable
        && !start_seen && !stop_seen |=> code == `CODE_DATA_NACK)
        else $error("nacked byte not reported as 0xC0");

    last_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
        state == i2c_st_pkg::ST_WAIT && code == `CODE_LAST_ACK && resume |=> state == i2c_st_pkg::ST_IDLE)
        else $error("0xC8 did not end the transfer");

    ack_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(state == i2c_st_pkg::ST_ADDR_ACK) |-> $past(ctrl.ack_enable) && sda_oe)
        else $error("address acknowledged with ack_enable low");

    bus_error_a: assert property (@(posedge clock) disable iff (!rst_n)
        (start_seen || stop_seen) && ctrl.enable && (state == i2c_st_pkg::ST_TX ||
        (state == i2c_st_pkg::ST_ADDR && bit_cnt != 4'h0))
        |=> state == i2c_st_pkg::ST_ERROR && code == `CODE_BUS_ERROR ##1 ctrl.job_done_flag)
        else $error("illegal START not reported as bus error");

    recover_a: assert property (@(posedge clock) disable iff (!rst_n)
        state == i2c_st_pkg::ST_ERROR && recover && ctrl.enable
        |=> state == i2c_st_pkg::ST_IDLE && !ctrl.stop_request && ctrl.ack_enable == $past(writedata[`CTRL_ACK_BIT]))
        else $error("recovery did not return to idle");

    release_a: assert property (@(posedge clock) disable iff (!rst_n)
        state == i2c_st_pkg::ST_ERROR |-> !scl_oe && !sda_oe)
        else $error("lines held during bus error");

    stretch_a: assert property (@(posedge clock) disable iff (!rst_n)
        state == i2c_st_pkg::ST_WAIT && ctrl.job_done_flag && !resume |=> scl_oe && ctrl.job_done_flag)
        else $error("SCL not stretched while flag set");

    ignore_a: assert property (@(posedge clock) disable iff (!rst_n)
        state == i2c_st_pkg::ST_IDLE && !start_drive ##1 state == i2c_st_pkg::ST_IDLE |-> !sda_oe)
        else $error("SDA driven while not addressed");

endmodule : i2c_slave_tx_status

// *** testbench/i2c_master_model.sv ***
// Behavioural two-wire master receiver facing the slave transmitter.
// Assumes the bench resolves each line from all open-drain enables with a pull-up.
`timescale 1ns/1ps

module i2c_master_model (
    output logic      scl_oe,
    output logic      sda_oe,
    input  wire logic scl_line,
    input  wire logic sda_line
);
    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    // SDA moves only while SCL is low; a stretched SCL is waited out.
    task automatic bit_io(input logic b, output logic r);
        sda_oe = !b;
        #50;
        scl_oe = 1'b0;
        wait (scl_line === 1'b1);
        #50;
        r = sda_line;
        #50;
        scl_oe = 1'b1;
        #50;
    endtask : bit_io

    // Works from idle and as a repeated start.
    task automatic start_cond();
        sda_oe = 1'b0;
        #50;
        scl_oe = 1'b0;
        wait (scl_line === 1'b1);
        #50;
        sda_oe = 1'b1;
        #50;
        scl_oe = 1'b1;
        #50;
    endtask : start_cond

    task automatic stop_cond();
        sda_oe = 1'b1;
        #50;
        scl_oe = 1'b0;
        wait (scl_line === 1'b1);
        #50;
        sda_oe = 1'b0;
        #100;
    endtask : stop_cond

    // Sends n bits MSB first; a whole byte also gets its acknowledge bit.
    task automatic xfer(input int n, input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack_out);
        ack_out = 1'b1;
        q = 8'hFF;
        for (int i = 0; i < n; i++)
            bit_io(d[7 - i], q[7 - i]);
        if (n == 8)
            bit_io(ack_in, ack_out);
    endtask : xfer
endmodule : i2c_master_model

// *** testbench/i2c_slave_tx_status_test.sv ***
// Self-checking bench of the slave transmitter with a master receiver on the wires.
// Assumes the register map of the design and an Avalon slave that may insert wait states.
`timescale 1ns/1ps
`include "i2c_st_defines.svh"

module i2c_slave_tx_status_test;
    logic        clock;
    logic        rst_n;
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        irq;
    logic        scl_oe_d, sda_oe_d, scl_oe_m, sda_oe_m;
    logic        scl_out_d, sda_out_d;
    wire         scl_line = !(scl_oe_d | scl_oe_m);
    wire         sda_line = !(sda_oe_d | sda_oe_m);
    int          n_fail, check_count;
    logic [31:0] seed;
    logic [7:0]  expq[$];
    logic [7:0]  q;
    logic        ak;

    i2c_slave_tx_status uut (.clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .scl_in(scl_line), .scl_out(scl_out_d), .scl_oe(scl_oe_d), .sda_in(sda_line), .sda_out(sda_out_d),
        .sda_oe(sda_oe_d));
    i2c_master_model master (.scl_oe(scl_oe_m), .sda_oe(sda_oe_m), .scl_line(scl_line), .sda_line(sda_line));

    always #12.5 clock = ~clock;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task results();
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // The request stands until the edge that sees waitrequest low; data is taken and the request dropped there.
    task automatic bus(input logic w, input logic [2:0] r, input logic [31:0] d, output logic [31:0] v);
        @(posedge clock);
        read <= !w;
        write <= w;
        address <= {r, 2'h0};
        writedata <= d;
        do
            @(posedge clock);
        while (waitrequest !== 1'b0);
        v = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [2:0] r, input logic [31:0] e);
        logic [31:0] v;
        bus(1'b0, r, 32'h0, v);
        chk(v, e);
    endtask : rd

    task automatic wr(input logic [2:0] r, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, r, d, v);
    endtask : wr

    task automatic wait_hi(input logic sel);
        for (int k = 0; k < 4000 && (sel ? sda_oe_d : irq) !== 1'b1; k++)
            @(negedge clock);
        chk({31'h0, sel ? sda_oe_d : irq}, 32'h1);
    endtask : wait_hi

    // Software side of one flagged state: check, optionally load a byte, resume.
    task automatic step(input logic [7:0] code, input logic load, input logic [7:0] ctl);
        logic [31:0] d;
        wait_hi(1'b0);
        rd(`REG_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rd(`REG_STATUS, {24'h0, code});
        chk({31'h0, scl_oe_d}, 32'h1);
        d = xs();
        if (load)
            expq.push_back(d[7:0]);
        if (load)
            wr(`REG_DATA, {24'h0, d[7:0]});
        wr(`REG_CONTROL, {24'h0, ctl});
    endtask : step

    task automatic mread(input logic ackm);
        logic [7:0] v;
        logic       a;
        master.xfer(8, 8'hFF, !ackm, v, a);
        chk({24'h0, v}, expq.size() ? {24'h0, expq.pop_front()} : 32'hFF);
    endtask : mread

    initial
    begin
        #500000;
        n_fail++;
        results();
    end

    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h0;
        seed = 32'h63;
        n_fail = 0;
        check_count = 0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(`REG_STATUS, 32'hF8);
        rd(3'h6, 32'h0);
        wr(`REG_OWN_ADDR, 32'h55);
        wr(`REG_IRQ_MASK, 32'h07);
        wr(`REG_CONTROL, 32'h44);
        master.start_cond();
        fork
            master.xfer(8, 8'h55, 1'b1, q, ak);
            step(`CODE_OWN_READ, 1'b1, 8'hC4);
        join
        chk({31'h0, ak}, 32'h0);
        fork
            mread(1'b1);
            step(`CODE_DATA_ACK, 1'b1, 8'h84);
        join
        fork
            mread(1'b1);
            step(`CODE_LAST_ACK, 1'b0, 8'hC4);
        join
        mread(1'b1);
        rd(`REG_STATUS, 32'hF8);
        master.stop_cond();
        master.start_cond();
        fork
            master.xfer(8, 8'h55, 1'b1, q, ak);
            step(`CODE_OWN_READ, 1'b1, 8'h84);
        join
        fork
            mread(1'b0);
            step(`CODE_DATA_NACK, 1'b0, 8'hE4);
        join
        master.start_cond();
        fork
            master.xfer(8, 8'h55, 1'b1, q, ak);
            step(`CODE_ARB_READ, 1'b1, 8'h84);
        join
        chk({31'h0, ak}, 32'h0);
        fork
            mread(1'b0);
            step(`CODE_DATA_NACK, 1'b0, 8'hA4);
        join
        master.start_cond();
        master.xfer(8, 8'h55, 1'b1, q, ak);
        chk({31'h0, ak}, 32'h1);
        chk({31'h0, sda_oe_d}, 32'h0);
        master.stop_cond();
        wait_hi(1'b1);
        rd(`REG_IRQ_STATUS, 32'h4);
        wr(`REG_CONTROL, 32'h44);
        repeat (20) @(posedge clock);
        master.start_cond();
        master.xfer(4, 8'h55, 1'b1, q, ak);
        master.stop_cond();
        wait_hi(1'b0);
        wr(`REG_IRQ_MASK, 32'h00);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0);
        wr(`REG_IRQ_MASK, 32'h07);
        @(negedge clock);
        chk({31'h0, irq}, 32'h1);
        rd(`REG_IRQ_STATUS, 32'h3);
        rd(`REG_STATUS, 32'h00);
        wr(`REG_CONTROL, 32'hD4);
        rd(`REG_CONTROL, 32'h44);
        chk({30'h0, scl_oe_d, sda_oe_d}, 32'h0);
        chk({30'h0, scl_out_d, sda_out_d}, 32'h0);
        rd(`REG_STATUS, 32'hF8);
        results();
    end
endmodule : i2c_slave_tx_status_test
